// [verilog/mpc_regs.sv]
`timescale 1ns/10ps
// Notes on behaviour
// - Gap total is a 7-bit count in bits 0-6, in transmit clock periods.
// - Gap first part is a 7-bit count in bits 8-14; bits 7, 15 reserved.
// - Gap resets to 1018h in MII or PMD mode, 4060h in 10BASE-T mode.
// - Request bit 0 starts one management read and clears itself.
// - Request bit 1 keeps reading repeatedly until cleared.
// - Register 04h resets to 061Fh; its meaning follows the interface mode.
// - MII mode: bits 0-4 are register number, bits 8-12 PHY address.
// - MII mode: bit 15 disables the internal signal-quality-error check.
// - PMD mode: bit 0 drives loopback pin, bit 1 drives fiber-off pin.
// - 10BASE-T mode: bits 0-4 drive loopback, cable, polarity, long, duplex pins.
// - 10BASE-T mode: bits 8, 9, 11, 12 drive filter, link, port select pins.
// - Writing the write-value register stores it and, in MII mode with the engine idle, starts a management write.
// - Write-value and read-value registers have no defined reset value.
// - Read-value register returns the data of the last management read.
// - Indicator bit 0 is busy; read data is valid once it is zero.
// - Indicator bit 1 shows repeat reading until software clears the request.
// - Indicator bit 2 stays set until the first repeated read completes.
// - Indicator register is read-only, resets to zero, bits 3-15 reserved.
// - Interface mode is configuration bits 9:8: MII, PMD, 10BASE-T, reserved.
module mpc_regs (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic hostCs_n,
	input wire logic hostRw,
	input wire logic [4:0] hostAddr,
	input wire logic [15:0] hostWrData,
	output logic [15:0] hostRdData,
	input wire logic [15:0] configReg,
	output logic [6:0] gapTotal,
	output logic [6:0] gapFirstPart,
	output logic sqeCheckDisable,
	output logic phyLoopback_n,
	output logic fiberTxOff_n,
	output logic cableTypeSelect,
	output logic autoPolarityEnable,
	output logic longCable_n,
	output logic autoDuplex_n,
	output logic filterDisable,
	output logic linkDisable_n,
	output logic phyPowerDown_n,
	output logic twistedPairPort_n,
	output logic attachmentPort_n,
	output logic mdc,
	output logic mdioOut,
	output logic mdioOe,
	input wire logic mdioIn
);
	import mpc_pkg::*;

	mpc_mode_t mode;
	logic [15:0] gap_ff, nxt_gap, ctl_ff, nxt_ctl, wv_ff, nxt_wv, rv_ff, nxt_rv;
	logic [15:0] rd_ff, nxt_rd;
	logic repeat_ff, nxt_repeat, pending_ff, nxt_pending;
	logic gapInit_ff, nxt_gapInit, repCycle_ff, nxt_repCycle;
	logic cs_ff, nxt_cs;
	logic wr_last, nxt_wrLast;
	logic start, startWr, engBusy, engDone;
	logic [15:0] engRd;
	logic [15:0] pins_ff, nxt_pins;
	logic [1:0] pmdPins_ff, nxt_pmdPins;
	logic wrStrobe, rdStrobe;

	// Interface mode decoded from configuration bits 9:8.
	assign mode = mpc_mode_t'(configReg[MODE_LSB+1:MODE_LSB]);

	// A host access is taken on the first clock with chip select low.
	assign wrStrobe = !hostCs_n && cs_ff && !hostRw;
	assign rdStrobe = !hostCs_n && cs_ff && hostRw;

	// Gap reset value selected by mode.
	function automatic logic [15:0] gapDefault(input mpc_mode_t m);
		return (m == MODE_TENBT) ? GAP_RESET_SLOW : GAP_RESET_FAST;
	endfunction

	// Writable mask of register 04h in each mode.
	function automatic logic [15:0] ctlMask(input mpc_mode_t m);
		case (m)
			MODE_MII: ctlMask = MII_CONTROL_MASK;
			MODE_PMD: ctlMask = PMD_CONTROL_MASK;
			MODE_TENBT: ctlMask = TENBT_CONTROL_MASK;
			default: ctlMask = 16'h0000;
		endcase
	endfunction

	// Register file next values and management command launch.
	always_comb begin
		nxt_cs = hostCs_n;
		nxt_gap = gap_ff;
		nxt_ctl = ctl_ff;
		nxt_wv = wv_ff;
		nxt_rv = rv_ff;
		nxt_repeat = repeat_ff;
		nxt_pending = pending_ff;
		nxt_gapInit = 1'b0;
		nxt_repCycle = repCycle_ff;
		start = 1'b0;
		startWr = 1'b0;
		if (gapInit_ff) begin
			nxt_gap = gapDefault(mode);
		end
		if (wrStrobe) begin
			case (hostAddr)
				ADDR_GAP: nxt_gap = hostWrData & GAP_MASK;
				ADDR_CONTROL: begin
					nxt_ctl = (ctl_ff & ~ctlMask(mode)) | (hostWrData & ctlMask(mode));
				end
				ADDR_WRITE_VALUE: begin
					nxt_wv = hostWrData;
					if (mode == MODE_MII && !engBusy) begin
						start = 1'b1;
						startWr = 1'b1;
					end
				end
				ADDR_REQUEST: begin
					if (mode == MODE_MII) begin
						nxt_repeat = hostWrData[REQ_REPEAT_BIT];
						if (hostWrData[REQ_REPEAT_BIT] && !repeat_ff) begin
							nxt_pending = 1'b1;
						end
						if (!hostWrData[REQ_REPEAT_BIT]) begin
							nxt_pending = 1'b0;
						end
						// Single read bit is a pulse and never stored.
						if (hostWrData[REQ_SINGLE_BIT] && !engBusy) begin
							start = 1'b1;
						end
					end
				end
				default: begin
				end
			endcase
		end
		// Repeated reading relaunches on the cycle after the engine's done pulse.
		if (repeat_ff && !engBusy && !start && !engDone) begin
			start = 1'b1;
			nxt_repCycle = 1'b1;
		end
		if (engDone) begin
			if (!wr_last) begin
				nxt_rv = engRd;
				// A fresh repeat request in this cycle keeps the flag set.
				if (repCycle_ff && repeat_ff) begin
					nxt_pending = 1'b0;
				end
			end
			nxt_repCycle = 1'b0;
		end
	end

	// Remembers whether the running frame is a write.
	always_comb begin
		nxt_wrLast = start ? startWr : wr_last;
	end

	// Read multiplexer; reserved and unmapped reads return zero.
	always_comb begin
		nxt_rd = rd_ff;
		if (rdStrobe) begin
			case (hostAddr)
				ADDR_GAP: nxt_rd = gap_ff & GAP_MASK;
				ADDR_CONTROL: nxt_rd = ctl_ff;
				ADDR_WRITE_VALUE: nxt_rd = wv_ff;
				ADDR_READ_VALUE: nxt_rd = rv_ff;
				ADDR_INDICATORS: nxt_rd = {13'h0000, pending_ff, repeat_ff, engBusy};
				default: nxt_rd = 16'h0000;
			endcase
		end
	end

	// Pin levels follow register 04h according to the interface mode.
	always_comb begin
		nxt_pins = pins_ff;
		nxt_pmdPins = pmdPins_ff;
		case (mode)
			MODE_MII: nxt_pins[SQE_DISABLE_BIT] = ctl_ff[SQE_DISABLE_BIT];
			MODE_PMD: begin
				nxt_pmdPins = ctl_ff[1:0];
				nxt_pins[0] = ctl_ff[0];
			end
			MODE_TENBT: nxt_pins[12:0] = ctl_ff[12:0];
			default: begin
			end
		endcase
	end

	// State registers; the gap default loads on the first clock after release.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			gap_ff <= GAP_RESET_FAST;
			gapInit_ff <= 1'b1;
			ctl_ff <= CONTROL_RESET;
			repeat_ff <= 1'b0;
			pending_ff <= 1'b0;
			repCycle_ff <= 1'b0;
			wr_last <= 1'b0;
			cs_ff <= 1'b1;
			rd_ff <= 16'h0000;
			pins_ff <= CONTROL_RESET;
			pmdPins_ff <= CONTROL_RESET[1:0];
		end else begin
			gap_ff <= nxt_gap;
			gapInit_ff <= nxt_gapInit;
			ctl_ff <= nxt_ctl;
			repeat_ff <= nxt_repeat;
			pending_ff <= nxt_pending;
			repCycle_ff <= nxt_repCycle;
			wr_last <= nxt_wrLast;
			cs_ff <= nxt_cs;
			rd_ff <= nxt_rd;
			pins_ff <= nxt_pins;
			pmdPins_ff <= nxt_pmdPins;
		end
	end

	// Data registers carry no reset value.
	always_ff @(posedge ref_clk) begin
		wv_ff <= nxt_wv;
		rv_ff <= nxt_rv;
	end

	// Management frame engine; uses PHY address and register number fields.
	mpc_mgmt_engine #(
		.HALF_CYCLES(MDC_HALF_CYCLES)
	) uEngine (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.start(start),
		.isWrite(startWr),
		.phyAddr(ctl_ff[PHY_ADDRESS_LSB+4:PHY_ADDRESS_LSB]),
		.regNum(ctl_ff[REG_NUMBER_LSB+4:REG_NUMBER_LSB]),
		.wrData(nxt_wv),
		.busy(engBusy),
		.done(engDone),
		.rdData(engRd),
		.mdc(mdc),
		.mdioOut(mdioOut),
		.mdioOe(mdioOe),
		.mdioIn(mdioIn)
	);

	assign hostRdData = rd_ff;
	assign gapTotal = gap_ff[GAP_TOTAL_LSB+6:GAP_TOTAL_LSB];
	assign gapFirstPart = gap_ff[GAP_FIRST_LSB+6:GAP_FIRST_LSB];
	assign sqeCheckDisable = pins_ff[SQE_DISABLE_BIT];
	assign phyLoopback_n = pins_ff[0];
	assign fiberTxOff_n = pmdPins_ff[1];
	assign cableTypeSelect = pins_ff[1];
	assign autoPolarityEnable = pins_ff[2];
	assign longCable_n = pins_ff[3];
	assign autoDuplex_n = pins_ff[4];
	assign filterDisable = pins_ff[8];
	assign linkDisable_n = pins_ff[9];
	assign phyPowerDown_n = pins_ff[10];
	assign twistedPairPort_n = pins_ff[11];
	assign attachmentPort_n = pins_ff[12];
endmodule

// [common/mpc_pkg.sv]
package mpc_pkg;
	// Register indices on the host address port.
	localparam logic [4:0] ADDR_CONFIG = 5'h00;
	localparam logic [4:0] ADDR_GAP = 5'h02;
	localparam logic [4:0] ADDR_REQUEST = 5'h03;
	localparam logic [4:0] ADDR_CONTROL = 5'h04;
	localparam logic [4:0] ADDR_WRITE_VALUE = 5'h05;
	localparam logic [4:0] ADDR_READ_VALUE = 5'h06;
	localparam logic [4:0] ADDR_INDICATORS = 5'h07;
	// Reset values.
	localparam logic [15:0] GAP_RESET_FAST = 16'h1018;
	localparam logic [15:0] GAP_RESET_SLOW = 16'h4060;
	localparam logic [15:0] CONTROL_RESET = 16'h061F;
	// Writable bit masks.
	localparam logic [15:0] GAP_MASK = 16'h7F7F;
	localparam logic [15:0] MII_CONTROL_MASK = 16'h9F1F;
	localparam logic [15:0] PMD_CONTROL_MASK = 16'h0003;
	localparam logic [15:0] TENBT_CONTROL_MASK = 16'h1F1F;
	// Field positions.
	localparam int GAP_TOTAL_LSB = 0;
	localparam int GAP_FIRST_LSB = 8;
	localparam int REQ_SINGLE_BIT = 0;
	localparam int REQ_REPEAT_BIT = 1;
	localparam int REG_NUMBER_LSB = 0;
	localparam int PHY_ADDRESS_LSB = 8;
	localparam int SQE_DISABLE_BIT = 15;
	localparam int MODE_LSB = 8;
	// Management serial clock divider: MDC period of at least 400 ns.
	localparam int MDC_MIN_NS = 400;
	localparam int CLK_PERIOD_NS = 4;
	localparam int MDC_HALF_CYCLES = (MDC_MIN_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
	// Interface modes.
	typedef enum logic [1:0] {
		MODE_MII = 2'h0,
		MODE_PMD = 2'h1,
		MODE_TENBT = 2'h2,
		MODE_RSVD = 2'h3
	} mpc_mode_t;
	typedef enum logic [1:0] {OP_READ, OP_WRITE} mpc_op_t;
endpackage

// [verilog/mpc_mgmt_engine.sv]
`timescale 1ns/10ps
// Serial management engine: runs one read or write frame on MDC/MDIO.
module mpc_mgmt_engine #(
	parameter int HALF_CYCLES = mpc_pkg::MDC_HALF_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic isWrite,
	input wire logic [4:0] phyAddr,
	input wire logic [4:0] regNum,
	input wire logic [15:0] wrData,
	output logic busy,
	output logic done,
	output logic [15:0] rdData,
	output logic mdc,
	output logic mdioOut,
	output logic mdioOe,
	input wire logic mdioIn
);
	import mpc_pkg::*;

	initial begin
		if (HALF_CYCLES < 1 || HALF_CYCLES > 256) begin
			$error("HALF_CYCLES must lie between 1 and 256");
		end
	end

	logic [7:0] divCnt_ff, nxt_divCnt;
	logic [6:0] bitCnt_ff, nxt_bitCnt;
	logic [63:0] shift_ff, nxt_shift;
	logic [15:0] rdData_ff, nxt_rdData;
	logic busy_ff, nxt_busy, done_ff, nxt_done, mdc_ff, nxt_mdc;
	logic oe_ff, nxt_oe, wr_ff, nxt_wr;

	// Frame: 32 preamble ones, start, op, addresses, turnaround, 16 data bits.
	always_comb begin
		nxt_divCnt = divCnt_ff;
		nxt_bitCnt = bitCnt_ff;
		nxt_shift = shift_ff;
		nxt_rdData = rdData_ff;
		nxt_busy = busy_ff;
		nxt_done = 1'b0;
		nxt_mdc = mdc_ff;
		nxt_oe = oe_ff;
		nxt_wr = wr_ff;
		if (!busy_ff) begin
			if (start) begin
				nxt_busy = 1'b1;
				nxt_wr = isWrite;
				nxt_bitCnt = 7'd0;
				nxt_divCnt = 8'd0;
				nxt_oe = 1'b1;
				nxt_shift = {32'hFFFFFFFF, 2'b01, isWrite ? 2'b01 : 2'b10, phyAddr, regNum,
					2'b10, isWrite ? wrData : 16'h0000};
			end
		end else if (divCnt_ff == 8'(HALF_CYCLES - 1)) begin
			nxt_divCnt = 8'd0;
			nxt_mdc = ~mdc_ff;
			if (mdc_ff) begin
				// Falling edge: advance to the next bit.
				nxt_shift = {shift_ff[62:0], 1'b0};
				nxt_bitCnt = bitCnt_ff + 7'd1;
				if (!wr_ff && bitCnt_ff == 7'd45) begin
					nxt_oe = 1'b0;
				end
				if (bitCnt_ff == 7'd63) begin
					nxt_busy = 1'b0;
					nxt_done = 1'b1;
					nxt_oe = 1'b0;
				end
			end else if (!wr_ff && bitCnt_ff >= 7'd48) begin
				// Rising edge: capture read data.
				nxt_rdData = {rdData_ff[14:0], mdioIn};
			end
		end else begin
			nxt_divCnt = divCnt_ff + 8'd1;
		end
	end

	// Engine state registers.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			divCnt_ff <= 8'h00;
			bitCnt_ff <= 7'h00;
			shift_ff <= 64'h0;
			rdData_ff <= 16'h0000;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			mdc_ff <= 1'b0;
			oe_ff <= 1'b0;
			wr_ff <= 1'b0;
		end else begin
			divCnt_ff <= nxt_divCnt;
			bitCnt_ff <= nxt_bitCnt;
			shift_ff <= nxt_shift;
			rdData_ff <= nxt_rdData;
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
			mdc_ff <= nxt_mdc;
			oe_ff <= nxt_oe;
			wr_ff <= nxt_wr;
		end
	end

	assign busy = busy_ff;
	assign done = done_ff;
	assign rdData = rdData_ff;
	assign mdc = mdc_ff;
	assign mdioOut = shift_ff[63];
	assign mdioOe = oe_ff;
endmodule

// [dv/mpc_regs_properties.sv]
`timescale 1ns/10ps
// Watches the host port and the pin outputs of the register bank.
module mpc_regs_properties
	import mpc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic hostCs_n,
	input wire logic hostRw,
	input wire logic [4:0] hostAddr,
	input wire logic [15:0] hostWrData,
	input wire logic [15:0] hostRdData,
	input wire logic [15:0] configReg,
	input wire logic [6:0] gapTotal,
	input wire logic [6:0] gapFirstPart,
	input wire logic sqeCheckDisable,
	input wire logic phyLoopback_n,
	input wire logic fiberTxOff_n,
	input wire logic mdioOe
);
	logic csPrev_ff;
	logic nxt_csPrev;
	logic take;
	logic wrTake;
	logic [1:0] mode;
	// An access is taken on the edge where chip select is newly low.
	always_comb begin
		nxt_csPrev = hostCs_n;
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			csPrev_ff <= 1'b1;
		end else begin
			csPrev_ff <= nxt_csPrev;
		end
	end
	// Decoded access strobes and the interface mode.
	assign take = csPrev_ff && !hostCs_n;
	assign wrTake = take && !hostRw;
	assign mode = configReg[MODE_LSB +: 2];
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	gap_write_a: assert property (wrTake && hostAddr == ADDR_GAP |=>
		gapTotal == $past(hostWrData[6:0]) && gapFirstPart == $past(hostWrData[14:8]))
		else $error("gap fields differ from write");
	gap_reset_a: assert property ($rose(rst_n) |=>
		{gapFirstPart, gapTotal} == ((mode == MODE_TENBT) ? 14'h2060 : 14'h0818))
		else $error("gap default wrong for mode");
	ctrl_reset_a: assert property ($rose(rst_n) |->
		!sqeCheckDisable && fiberTxOff_n && phyLoopback_n)
		else $error("control pins not at reset level");
	pmd_pins_a: assert property (wrTake && hostAddr == ADDR_CONTROL && mode == MODE_PMD |->
		##2 {fiberTxOff_n, phyLoopback_n} == $past(hostWrData[1:0], 2))
		else $error("pmd pins differ from write");
	sqe_write_a: assert property (wrTake && hostAddr == ADDR_CONTROL && mode == MODE_MII |->
		##2 sqeCheckDisable == $past(hostWrData[15], 2))
		else $error("sqe disable differs from write");
	ind_reserved_a: assert property (take && hostRw && hostAddr == ADDR_INDICATORS |->
		##2 hostRdData[15:3] == 13'h0000)
		else $error("indicator reserved bits set");
	ctrl_reserved_a: assert property (take && hostRw && hostAddr == ADDR_CONTROL |->
		##2 hostRdData[14:13] == 2'h0 && hostRdData[7:5] == 3'h0)
		else $error("control reserved bits set");
	req_start_a: assert property (wrTake && hostAddr == ADDR_REQUEST && mode == MODE_MII
		&& hostWrData[0] |-> ##[1:200] mdioOe)
		else $error("single read did not start");
	wv_start_a: assert property (wrTake && hostAddr == ADDR_WRITE_VALUE && mode == MODE_MII
		|-> ##[1:200] mdioOe)
		else $error("management write did not start");
	cover property (wrTake && hostAddr == ADDR_REQUEST);
	cover property (wrTake && hostAddr == ADDR_CONTROL && mode == MODE_PMD);
	cover property ($rose(mdioOe));
endmodule

bind mpc_regs mpc_regs_properties chk (.ref_clk(ref_clk), .rst_n(rst_n), .hostCs_n(hostCs_n),
	.hostRw(hostRw), .hostAddr(hostAddr), .hostWrData(hostWrData), .hostRdData(hostRdData),
	.configReg(configReg), .gapTotal(gapTotal), .gapFirstPart(gapFirstPart),
	.sqeCheckDisable(sqeCheckDisable), .phyLoopback_n(phyLoopback_n),
	.fiberTxOff_n(fiberTxOff_n), .mdioOe(mdioOe));

// [dv/mpc_phy_model.sv]
`timescale 1ns/10ps
// Far-end management device: decodes headers, answers reads, records writes.
module mpc_phy_model (
	input wire logic mdc,
	input wire logic mdioOut,
	input wire logic mdioOe,
	output logic mdioIn
);
	logic [13:0] hist = 14'h3FFF;
	logic [5:0] cnt = 6'h00;
	logic isRd = 1'b0;
	logic phyOe = 1'b0;
	logic phyBit = 1'b1;
	logic [9:0] hdr = 10'h000;
	logic [15:0] lastWr = 16'h0000;
	logic [15:0] rdVal;
	// Read data depends on the register number, so a wrong address shows.
	assign rdVal = 16'hC350 ^ {11'h000, hdr[4:0]};
	// The line has a pull-up, so it reads high when nobody drives it.
	assign mdioIn = mdioOe ? mdioOut : (phyOe ? phyBit : 1'b1);
	// Samples on the rising serial clock edge and drives just after it.
	always @(posedge mdc) begin
		hist <= (cnt == 6'h00) ? {hist[12:0], mdioIn} : 14'h3FFF;
		if (cnt != 6'h00) begin
			cnt <= cnt - 6'h01;
			if (isRd) begin
				phyOe <= (cnt != 6'h01);
				phyBit <= (cnt == 6'h12) ? 1'b0 : rdVal[cnt - 6'h02];
			end else if (cnt <= 6'h10) begin
				lastWr <= {lastWr[14:0], mdioIn};
			end
		end else if (mdioOe && hist[12:11] == 2'h1) begin
			cnt <= 6'h12;
			isRd <= hist[10];
			hdr <= {hist[8:0], mdioIn};
		end
	end
endmodule

// [dv/mac_phy_control_registers_bench.sv]
`timescale 1ns/10ps
// Drives the host port through register accesses and compares results.
module mac_phy_control_registers_bench;
	import mpc_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic hostCs_n = 1'b1;
	logic hostRw = 1'b1;
	logic [4:0] hostAddr = 5'h00;
	logic [15:0] hostWrData = 16'h0000;
	logic [15:0] configReg = 16'h0002;
	logic [15:0] hostRdData;
	logic [6:0] gapTotal;
	logic [6:0] gapFirstPart;
	wire [15:0] pin;
	wire mdc, mdioOut, mdioOe, mdioIn;
	logic [15:0] rd;
	int num_errors = 0;
	int cmp_count = 0;
	mpc_regs dut (.ref_clk(ref_clk), .rst_n(rst_n), .hostCs_n(hostCs_n), .hostRw(hostRw),
		.hostAddr(hostAddr), .hostWrData(hostWrData), .hostRdData(hostRdData),
		.configReg(configReg), .gapTotal(gapTotal), .gapFirstPart(gapFirstPart),
		.sqeCheckDisable(pin[15]), .phyLoopback_n(pin[0]), .fiberTxOff_n(pin[5]),
		.cableTypeSelect(pin[1]), .autoPolarityEnable(pin[2]), .longCable_n(pin[3]),
		.autoDuplex_n(pin[4]), .filterDisable(pin[8]), .linkDisable_n(pin[9]),
		.phyPowerDown_n(pin[10]), .twistedPairPort_n(pin[11]), .attachmentPort_n(pin[12]),
		.mdc(mdc), .mdioOut(mdioOut), .mdioOe(mdioOe), .mdioIn(mdioIn));
	mpc_phy_model phy (.mdc(mdc), .mdioOut(mdioOut), .mdioOe(mdioOe), .mdioIn(mdioIn));
	// Clock at 250 MHz.
	always #2 ref_clk = ~ref_clk;
	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// One access per chip-select low; read data is settled two edges later.
	task automatic acc(input logic rw, input logic [4:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		hostCs_n <= 1'b0;
		hostRw <= rw;
		hostAddr <= a;
		hostWrData <= d;
		repeat (2) @(posedge ref_clk);
		hostCs_n <= 1'b1;
		#1 rd = hostRdData;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [4:0] a, input logic [15:0] e);
		acc(1'b1, a, 16'h0000);
		chk(rd, e);
	endtask
	// Polls the indicators until the masked bits clear, with a bound.
	task automatic waitInd(input logic [15:0] m);
		int n = 0;
		do begin
			repeat (20) @(posedge ref_clk);
			acc(1'b1, ADDR_INDICATORS, 16'h0000);
			n++;
		end while ((rd & m) !== 16'h0000 && n < 1000);
		chk(rd & m, 16'h0000);
	endtask
	// Reset for eight cycles with the chosen mode and full duplex set.
	task automatic doReset(input logic [1:0] m);
		@(posedge ref_clk);
		rst_n <= 1'b0;
		configReg <= {6'h00, m, 8'h02};
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
	endtask
	// Main sequence: MII registers and traffic, then the two pin modes.
	initial begin
		doReset(MODE_MII);
		rchk(ADDR_GAP, GAP_RESET_FAST);
		rchk(ADDR_CONTROL, CONTROL_RESET);
		rchk(ADDR_INDICATORS, 16'h0000);
		acc(1'b0, ADDR_GAP, 16'hFFFF);
		acc(1'b0, 5'h1F, 16'h0000);
		rchk(ADDR_GAP, 16'h7F7F);
		chk({1'b0, gapFirstPart, 1'b0, gapTotal}, 16'h7F7F);
		acc(1'b0, ADDR_CONTROL, 16'hFFFF);
		rchk(ADDR_CONTROL, 16'h9F1F);
		chk({15'h0000, pin[15]}, 16'h0001);
		acc(1'b0, ADDR_CONTROL, 16'h0A03);
		acc(1'b0, ADDR_REQUEST, 16'h0001);
		rchk(ADDR_INDICATORS, 16'h0001);
		waitInd(16'h0001);
		rchk(ADDR_READ_VALUE, 16'hC353);
		acc(1'b0, ADDR_WRITE_VALUE, 16'h1234);
		waitInd(16'h0001);
		chk(phy.lastWr, 16'h1234);
		chk({6'h00, phy.hdr}, 16'h0143);
		rchk(ADDR_WRITE_VALUE, 16'h1234);
		acc(1'b0, ADDR_REQUEST, 16'h0002);
		rchk(ADDR_INDICATORS, 16'h0007);
		waitInd(16'h0004);
		chk(rd & 16'h0002, 16'h0002);
		acc(1'b0, ADDR_REQUEST, 16'h0000);
		waitInd(16'h0007);
		rchk(ADDR_READ_VALUE, 16'hC353);
		doReset(MODE_TENBT);
		rchk(ADDR_GAP, GAP_RESET_SLOW);
		acc(1'b0, ADDR_CONTROL, 16'hFFFF);
		chk(pin & 16'h1F1F, 16'h1F1F);
		acc(1'b0, ADDR_CONTROL, 16'h0000);
		chk(pin & 16'h1F1F, 16'h0000);
		doReset(MODE_PMD);
		rchk(ADDR_GAP, GAP_RESET_FAST);
		acc(1'b0, ADDR_CONTROL, 16'hFFFE);
		chk({14'h0000, pin[5], pin[0]}, 16'h0002);
		// Reserved bits keep their reset ones; only the two pin bits change.
		rchk(ADDR_CONTROL, 16'h061E);
		stop_test();
	end
	// Cuts a hang short well beyond the expected run length.
	initial begin
		#300000;
		num_errors++;
		stop_test();
	end
endmodule
